/* File: design/cot_regs.sv */
// Purpose: Power readback high bits and carrier oscillator tuning
//          registers behind a three-wire serial control port.
// Assumes: Serial pins and frame pin are asynchronous to sys_clk_i and
//          slow enough for two-flop sampling; power and phase high
//          byte come from logic on sys_clk_i.
// Notes:   One instruction byte then one data byte per frame.
//
// Overview of operation
// - Read power bits [12:8] at 0x2D
// - Bytes 0x31..0x34 form tuning word, LSB first
// - Tuning word is signed twos complement
// - Byte writes only stage the tuning word
// - Commit on serial request or frame update
// - Bit 1 acknowledges serial tuning update
// - Bit 6 shows frame triggered update status
// - Bit 5 acknowledges phase reset
// - Phase reset loads 16-bit offset, input high byte and 0x35 low
// - Offset is twos complement, 0.0055 deg step
// - Reset: byte3 0x10, others and phase zero
// - High phase byte from phase_offset_high_bits_i, low 0x35
`include "cot_defines.svh"
module cot_regs
   import cot_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   input wire logic frame_update_i,
   input wire logic [12:0] avg_power_i,
   input wire logic [7:0] phase_offset_high_bits_i,
   output logic signed [31:0] frequency_setting_word_o,
   output logic [15:0] phase_start_o,
   output logic phase_load_o
);

   // ----------------------------------------------------------------------
   // Reset image
   // ----------------------------------------------------------------------
   localparam logic [31:0] TUNE_RST = {`COT_RST_TUNE_B3, `COT_RST_TUNE_B2,
                                       `COT_RST_TUNE_B1, `COT_RST_TUNE_B0};
   localparam cot_state_t STATE_RST = '{
      st: COT_IDLE,
      csn_s1: 1'b1,
      csn_s2: 1'b1,
      staged: TUNE_RST,
      active: TUNE_RST,
      phase_offset_low_bits: `COT_RST_PHASE_LOW,
      default: '0
   };

   cot_state_t r_ff;
   cot_state_t nxt_r;
   logic sclk_rise;
   logic sclk_fall;
   logic frm_rise;
   logic wr_en;
   logic [7:0] wr_data;

   // ----------------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------------
   function automatic logic [7:0] cot_read_byte(input logic [6:0] addr,
                                               input cot_state_t s,
                                               input logic [12:0] power);
      logic [7:0] val;
      val = `COT_RST_UNMAPPED;
      case (addr)
         `COT_ADDR_POWER_HIGH: begin
            val = {3'h0, power[12:8]};
         end
         `COT_ADDR_UPD_CTRL: begin
            val[`COT_BIT_TUNE_REQ] = s.tuning_update_req;
            val[`COT_BIT_TUNE_ACK] = s.tuning_update_ack;
            val[`COT_BIT_PH_REQ] = s.phase_reset_req;
            val[`COT_BIT_PH_ACK] = s.phase_reset_ack;
            val[`COT_BIT_FRAME_STAT] = s.frame_update_status;
         end
         `COT_ADDR_TUNE_B0: val = s.staged[7:0];
         `COT_ADDR_TUNE_B1: val = s.staged[15:8];
         `COT_ADDR_TUNE_B2: val = s.staged[23:16];
         `COT_ADDR_TUNE_B3: val = s.staged[31:24];
         `COT_ADDR_PHASE_LOW: val = s.phase_offset_low_bits;
         default: val = `COT_RST_UNMAPPED;
      endcase
      return val;
   endfunction

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      nxt_r.sclk_s1 = spi_sclk_i;
      nxt_r.sclk_s2 = r_ff.sclk_s1;
      nxt_r.sclk_d = r_ff.sclk_s2;
      nxt_r.sdi_s1 = spi_sdio_i;
      nxt_r.sdi_s2 = r_ff.sdi_s1;
      nxt_r.csn_s1 = spi_cs_n_i;
      nxt_r.csn_s2 = r_ff.csn_s1;
      nxt_r.frm_s1 = frame_update_i;
      nxt_r.frm_s2 = r_ff.frm_s1;
      nxt_r.frm_d = r_ff.frm_s2;
      sclk_rise = r_ff.sclk_s2 & ~r_ff.sclk_d;
      sclk_fall = ~r_ff.sclk_s2 & r_ff.sclk_d;
      frm_rise = r_ff.frm_s2 & ~r_ff.frm_d;
      wr_data = {r_ff.shin[6:0], r_ff.sdi_s2};
      wr_en = 1'b0;

      // Serial port framing
      if (r_ff.csn_s2) begin
         nxt_r.st = COT_IDLE;
         nxt_r.cnt = 5'h00;
         nxt_r.rd = 1'b0;
      end else begin
         unique case (r_ff.st)
            COT_IDLE: begin
               nxt_r.st = COT_INSTR;
               nxt_r.cnt = 5'h00;
            end
            COT_INSTR: begin
               if (sclk_rise) begin
                  nxt_r.shin = wr_data;
                  nxt_r.cnt = r_ff.cnt + 5'h01;
                  if (r_ff.cnt == `COT_INSTR_LAST) begin
                     nxt_r.rd = wr_data[7];
                     nxt_r.addr = wr_data[6:0];
                     nxt_r.dout = cot_read_byte(wr_data[6:0], r_ff, avg_power_i);
                     nxt_r.st = COT_DATA;
                  end
               end
            end
            COT_DATA: begin
               if (sclk_rise && r_ff.cnt < `COT_FRAME_BITS) begin
                  nxt_r.shin = wr_data;
                  nxt_r.cnt = r_ff.cnt + 5'h01;
                  wr_en = (r_ff.cnt == `COT_FRAME_LAST) && !r_ff.rd;
               end
               // Hold first read bit until the host has sampled it
               if (sclk_fall && r_ff.rd && r_ff.cnt > `COT_READ_FIRST) begin
                  nxt_r.dout = {r_ff.dout[6:0], 1'b0};
               end
            end
            default: begin
               nxt_r.st = COT_IDLE;
            end
         endcase
      end

      // Register writes; tuning bytes only stage
      if (wr_en) begin
         case (r_ff.addr)
            `COT_ADDR_UPD_CTRL: begin
               nxt_r.tuning_update_req = wr_data[`COT_BIT_TUNE_REQ];
               nxt_r.phase_reset_req = wr_data[`COT_BIT_PH_REQ];
            end
            `COT_ADDR_TUNE_B0: nxt_r.staged[7:0] = wr_data;
            `COT_ADDR_TUNE_B1: nxt_r.staged[15:8] = wr_data;
            `COT_ADDR_TUNE_B2: nxt_r.staged[23:16] = wr_data;
            `COT_ADDR_TUNE_B3: nxt_r.staged[31:24] = wr_data;
            `COT_ADDR_PHASE_LOW: nxt_r.phase_offset_low_bits = wr_data;
            default: nxt_r.addr = r_ff.addr;
         endcase
      end

      // Serial commit of staged word, ack held until request cleared
      if (r_ff.tuning_update_req && !r_ff.tuning_update_ack) begin
         nxt_r.active = r_ff.staged;
         nxt_r.tuning_update_ack = 1'b1;
      end else if (!r_ff.tuning_update_req) begin
         nxt_r.tuning_update_ack = 1'b0;
      end

      // Frame commit; status stays while frame signal is high
      if (frm_rise) begin
         nxt_r.active = r_ff.staged;
         nxt_r.frame_update_status = 1'b1;
      end else if (!r_ff.frm_s2) begin
         nxt_r.frame_update_status = 1'b0;
      end

      // Phase reset: one load pulse per request
      nxt_r.phase_load = 1'b0;
      if (r_ff.phase_reset_req && !r_ff.phase_reset_ack) begin
         nxt_r.phase_start = {phase_offset_high_bits_i,
                              r_ff.phase_offset_low_bits};
         nxt_r.phase_load = 1'b1;
         nxt_r.phase_reset_ack = 1'b1;
      end else if (!r_ff.phase_reset_req) begin
         nxt_r.phase_reset_ack = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         r_ff <= STATE_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign frequency_setting_word_o = $signed(r_ff.active);
   assign phase_start_o = r_ff.phase_start;
   assign phase_load_o = r_ff.phase_load;
   assign spi_sdio_o = r_ff.dout[7];
   assign spi_sdio_oe_o = (r_ff.st == COT_DATA) && r_ff.rd && !r_ff.csn_s2;

endmodule

/* File: pkg/cot_defines.svh */
// Purpose: Register offsets, field positions and reset values of the
//          carrier oscillator tuning register bank.
// Assumes: 7-bit register addresses, 8-bit registers.
// Notes:   Definitions only.
`ifndef COT_DEFINES_SVH
`define COT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define COT_ADDR_POWER_HIGH 7'h2D
`define COT_ADDR_UPD_CTRL 7'h30
`define COT_ADDR_TUNE_B0 7'h31
`define COT_ADDR_TUNE_B1 7'h32
`define COT_ADDR_TUNE_B2 7'h33
`define COT_ADDR_TUNE_B3 7'h34
`define COT_ADDR_PHASE_LOW 7'h35

// ----------------------------------------------------------------------
// Field positions in oscillator_update_control
// ----------------------------------------------------------------------
`define COT_BIT_TUNE_REQ 0
`define COT_BIT_TUNE_ACK 1
`define COT_BIT_PH_REQ 4
`define COT_BIT_PH_ACK 5
`define COT_BIT_FRAME_STAT 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define COT_RST_TUNE_B0 8'h00
`define COT_RST_TUNE_B1 8'h00
`define COT_RST_TUNE_B2 8'h00
`define COT_RST_TUNE_B3 8'h10
`define COT_RST_PHASE_LOW 8'h00
`define COT_RST_UNMAPPED 8'h00

// ----------------------------------------------------------------------
// Serial frame: 8 instruction bits then 8 data bits
// ----------------------------------------------------------------------
`define COT_INSTR_LAST 5'h07
`define COT_FRAME_LAST 5'h0F
`define COT_FRAME_BITS 5'h10
`define COT_READ_FIRST 5'h08

`endif

/* File: pkg/cot_pkg.sv */
// Purpose: Types of the carrier oscillator tuning register bank.
// Assumes: One clock domain.
// Notes:   Whole module state is one packed struct.
package cot_pkg;

   // ----------------------------------------------------------------------
   // Serial port phases, Gray coded
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      COT_IDLE = 2'h0,
      COT_INSTR = 2'h1,
      COT_DATA = 2'h3
   } cot_phase_t;

   // ----------------------------------------------------------------------
   // Module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      cot_phase_t st;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic sdi_s1;
      logic sdi_s2;
      logic csn_s1;
      logic csn_s2;
      logic frm_s1;
      logic frm_s2;
      logic frm_d;
      logic [4:0] cnt;
      logic [7:0] shin;
      logic rd;
      logic [6:0] addr;
      logic [7:0] dout;
      logic [31:0] staged;
      logic [31:0] active;
      logic tuning_update_req;
      logic tuning_update_ack;
      logic frame_update_status;
      logic phase_reset_req;
      logic phase_reset_ack;
      logic [7:0] phase_offset_low_bits;
      logic [15:0] phase_start;
      logic phase_load;
   } cot_state_t;

endpackage

/* File: tb/cot_host.sv */
// Purpose: Serial host model for cot_regs
// Assumes: Sclk phases of 5 clocks
// Notes:   Released line shows a toggling pattern
module cot_host (
   input wire logic sys_clk_i,
   input wire logic dev_sdio_i,
   input wire logic dev_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv = 1'b1;
   logic dat = 1'b0;
   logic junk = 1'b0;
   initial sclk_o = 1'b0;
   initial cs_n_o = 1'b1;
   assign pin_o = dev_oe_i ? dev_sdio_i : (drv ? dat : junk);
   always @(posedge sys_clk_i) junk <= ~junk;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #2;
   endtask
   task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [15:0] f;
      f = {rd, a, d};
      cs_n_o = 1'b0;
      cyc(4);
      for (int i = 15; i >= 0; i--) begin
         drv = !(rd && i < 8);
         dat = f[i];
         cyc(5);
         q = {q[6:0], pin_o};
         sclk_o = 1'b1;
         cyc(5);
         sclk_o = 1'b0;
      end
      cyc(5);
      cs_n_o = 1'b1;
      drv = 1'b1;
      cyc(5);
   endtask
endmodule

/* File: tb/cot_regs_bench.sv */
// Purpose: Self-checking bench for cot_regs
// Assumes: Host model drives the serial pins
// Notes:   Model keeps staged bytes, active word and control bits
module cot_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic frame_update_i = 1'b0;
   logic [12:0] avg_power_i = 13'h0000;
   logic [7:0] phase_offset_high_bits_i = 8'h00;
   wire sclk, cs_n, sdio, dev_o, dev_oe, ph_load;
   wire signed [31:0] freq;
   wire [15:0] ph_start;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int seed = 45;
   int ph_loads = 0;
   logic [7:0] mdl [7'h31:7'h35] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
   logic [31:0] act = 32'h1000_0000;
   logic tu = 1'b0;
   logic ph = 1'b0;
   logic frm = 1'b0;
   logic [15:0] ph_got;
   logic [7:0] q;
   always #12.5 sys_clk_i = ~sys_clk_i;
   cot_regs uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .spi_sclk_i(sclk),
      .spi_cs_n_i(cs_n), .spi_sdio_i(sdio), .spi_sdio_o(dev_o), .spi_sdio_oe_o(dev_oe),
      .frame_update_i(frame_update_i), .avg_power_i(avg_power_i),
      .phase_offset_high_bits_i(phase_offset_high_bits_i), .frequency_setting_word_o(freq),
      .phase_start_o(ph_start), .phase_load_o(ph_load));
   cot_host host (.sys_clk_i(sys_clk_i), .dev_sdio_i(dev_o), .dev_oe_i(dev_oe),
      .sclk_o(sclk), .cs_n_o(cs_n), .pin_o(sdio));
   always @(negedge sys_clk_i) begin
      cycles++;
      if (ph_load === 1'b1) begin
         ph_loads++;
         ph_got = ph_start;
      end
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      case (a)
         7'h2D: return {3'h0, avg_power_i[12:8]};
         7'h30: return {1'b0, frm, ph, ph, 2'h0, tu, tu};
         7'h31, 7'h32, 7'h33, 7'h34, 7'h35: return mdl[a];
         default: return 8'h00;
      endcase
   endfunction
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d, q);
      if (a >= 7'h31 && a <= 7'h35) mdl[a] = d;
      if (a == 7'h30) begin
         if (d[0] && !tu) act = {mdl[7'h34], mdl[7'h33], mdl[7'h32], mdl[7'h31]};
         tu = d[0];
         ph = d[4];
      end
   endtask
   task automatic rd(input logic [6:0] a);
      logic [7:0] e;
      e = exp_rd(a);
      host.xfer(1'b1, a, 8'h00, q);
      chk("read", {24'h0, q}, {24'h0, e});
   endtask
   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      avg_power_i = 13'($random(seed));
      repeat (4) @(posedge sys_clk_i);
      #2;
      reset_i = 1'b0;
      host.cyc(5);
      for (int a = 'h2D; a <= 'h36; a++) rd(7'(a));
      chk("freq", freq, act);
      for (int i = 0; i < 3; i++) begin
         for (int b = 'h31; b <= 'h33; b++) wr(7'(b), 8'($random(seed)));
         wr(7'h34, {i[0], 7'($random(seed))});
         chk("staged", freq, act);
         rd(7'h34);
         if (i < 2) begin
            wr(7'h30, 8'h01);
            chk("freq", freq, act);
            chk("sign", freq < 0, act[31]);
            rd(7'h30);
            wr(7'h30, 8'h00);
         end else begin
            frame_update_i = 1'b1;
            act = {mdl[7'h34], mdl[7'h33], mdl[7'h32], mdl[7'h31]};
            frm = 1'b1;
            host.cyc(10);
            chk("frame", freq, act);
            rd(7'h30);
            frame_update_i = 1'b0;
            frm = 1'b0;
            host.cyc(5);
         end
         rd(7'h30);
      end
      phase_offset_high_bits_i = 8'($random(seed));
      wr(7'h35, 8'($random(seed)));
      wr(7'h30, 8'h10);
      chk("loads", ph_loads, 1);
      chk("start", ph_got, {phase_offset_high_bits_i, mdl[7'h35]});
      rd(7'h30);
      wr(7'h30, 8'h00);
      rd(7'h30);
      wr(7'h2E, 8'hA5);
      wr(7'h2D, 8'hFF);
      avg_power_i = 13'($random(seed));
      rd(7'h2E);
      rd(7'h2D);
      finish_test();
   end
endmodule

/* File: tb/cot_regs_sva.sv */
// Purpose: Port checker for cot_regs
// Assumes: One clock, synchronous active high reset
// Notes:   Bound into every cot_regs instance
module cot_regs_sva (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_sdio_oe_o,
   input wire logic frame_update_i,
   input wire logic [7:0] phase_offset_high_bits_i,
   input wire logic signed [31:0] frequency_setting_word_o,
   input wire logic [15:0] phase_start_o,
   input wire logic phase_load_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_cs_idle;
      spi_cs_n_i [*6];
   endsequence
   property p_reset_vals;
      $fell(reset_i) |-> frequency_setting_word_o == 32'h1000_0000
         && phase_start_o == 16'h0000 && !phase_load_o;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong");
   property p_load_pulse;
      phase_load_o |=> !phase_load_o;
   endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("Load pulse too long");
   property p_phase_high;
      phase_load_o |-> phase_start_o[15:8] == $past(phase_offset_high_bits_i);
   endproperty
   a_phase_high: assert property (p_phase_high) else $error("Phase high byte wrong");
   property p_start_cause;
      $changed(phase_start_o) |-> phase_load_o;
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("Phase start moved");
   property p_freq_cause;
      $changed(frequency_setting_word_o) |-> frame_update_i || !spi_cs_n_i;
   endproperty
   a_freq_cause: assert property (p_freq_cause) else $error("Word moved uncaused");
   property p_load_in_frame;
      phase_load_o |-> !spi_cs_n_i;
   endproperty
   a_load_in_frame: assert property (p_load_in_frame) else $error("Load outside frame");
   property p_oe_idle;
      s_cs_idle |-> !spi_sdio_oe_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("Drive while idle");
   property p_oe_late;
      $rose(spi_sdio_oe_o) |-> !$past(spi_cs_n_i, 30);
   endproperty
   a_oe_late: assert property (p_oe_late) else $error("Drive too early");
endmodule

bind cot_regs cot_regs_sva u_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .spi_cs_n_i(spi_cs_n_i), .spi_sdio_oe_o(spi_sdio_oe_o), .frame_update_i(frame_update_i),
   .phase_offset_high_bits_i(phase_offset_high_bits_i),
   .frequency_setting_word_o(frequency_setting_word_o), .phase_start_o(phase_start_o),
   .phase_load_o(phase_load_o));
